// ### pkg/spm_map.vh
// register map, field positions, reset values and timing of the spi register port
`ifndef SPM_MAP_VH
`define SPM_MAP_VH

// ----------------------------------------------------------------------------
// word format
// ----------------------------------------------------------------------------
`define SPM_WORD_BITS 16
`define SPM_WR_FLAG_BIT 7
`define SPM_READ_TAIL 8'h00

// ----------------------------------------------------------------------------
// sensor output words, read only
// ----------------------------------------------------------------------------
`define SPM_ADDR_GYRO_X 8'h04
`define SPM_ADDR_GYRO_Y 8'h06
`define SPM_ADDR_GYRO_Z 8'h08
`define SPM_ADDR_ACCEL_X 8'h0a
`define SPM_ADDR_ACCEL_Y 8'h0c
`define SPM_ADDR_ACCEL_Z 8'h0e
`define SPM_ADDR_MAG_X 8'h10
`define SPM_ADDR_MAG_Y 8'h12
`define SPM_ADDR_MAG_Z 8'h14
`define SPM_ADDR_GYRO_TEMP 8'h16
`define SPM_ADDR_PCB_TEMP 8'h18

// ----------------------------------------------------------------------------
// configuration bytes, read and write
// ----------------------------------------------------------------------------
`define SPM_ADDR_BIST 8'h34
`define SPM_ADDR_READY 8'h35
`define SPM_ADDR_RATE 8'h36
`define SPM_ADDR_TBASE 8'h37
`define SPM_ADDR_RANGE 8'h38

`define SPM_RST_BIST 8'h00
`define SPM_RST_READY 8'h04
`define SPM_RST_RATE 8'h01
`define SPM_RST_TBASE 8'h01
`define SPM_RST_RANGE 8'h02

// ----------------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------------
`define SPM_BIST_GO_BIT 2
`define SPM_READY_EN_BIT 2
`define SPM_READY_POL_BIT 1
`define SPM_TBASE_LOCK_BIT 7

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SPM_MCLK_KHZ 25000
`define SPM_SCLK_MAX_KHZ 2000
`define SPM_SCLK_MIN_HALF_CYC ((`SPM_MCLK_KHZ + 2 * `SPM_SCLK_MAX_KHZ - 1) / (2 * `SPM_SCLK_MAX_KHZ))

`endif

// ### logic/spm_sync.v
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none

module spm_sync #(
	parameter WIDTH = 4,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	// pins in, synchronised out
	input wire [WIDTH-1:0] din,
	output reg [WIDTH-1:0] dout
);

	reg [WIDTH-1:0] meta_q;

	// first stage feeds only the second stage
	always @(posedge mclk) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			dout <= RST_VAL;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end

endmodule // spm_sync

`default_nettype wire

// ### logic/spm_cfg_regs.v
// configuration byte bank written one byte at a time from the serial port
`timescale 1ns/10ps
`default_nettype none
`include "spm_map.vh"

module spm_cfg_regs (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	// byte write port
	input wire wr_en,
	input wire [7:0] wr_addr,
	input wire [7:0] wr_data,
	// stored bytes
	output reg [7:0] builtin_test_ctrl,
	output reg [7:0] sample_ready_cfg,
	output reg [7:0] sample_rate_select,
	output reg [7:0] timebase_source_select,
	output reg [7:0] gyro_range_select
);

	// one byte per write; any address outside the bank leaves it unchanged
	always @(posedge mclk) begin
		if (!rst_n) begin
			builtin_test_ctrl <= `SPM_RST_BIST;
			sample_ready_cfg <= `SPM_RST_READY;
			sample_rate_select <= `SPM_RST_RATE;
			timebase_source_select <= `SPM_RST_TBASE;
			gyro_range_select <= `SPM_RST_RANGE;
		end else if (wr_en) begin
			case (wr_addr)
				`SPM_ADDR_BIST: builtin_test_ctrl <= wr_data;
				`SPM_ADDR_READY: sample_ready_cfg <= wr_data;
				`SPM_ADDR_RATE: sample_rate_select <= wr_data;
				`SPM_ADDR_TBASE: timebase_source_select <= wr_data;
				`SPM_ADDR_RANGE: gyro_range_select <= wr_data;
				default: builtin_test_ctrl <= builtin_test_ctrl;
			endcase
		end
	end

endmodule // spm_cfg_regs

`default_nettype wire

// ### logic/spm_spi_port.v
// spi slave register port: serial engine, register read mux, timebase lock
// Behaviour
// - slave only; master drives clock and select and starts every transfer
// - transfers are 16-bit words, most significant bit first both ways
// - clock idles high; output changes on falling, input sampled on rising
// - reads return one 16-bit word; writes carry one byte to one address
// - after a sync pulse stay external until reset with sync removed
// - self-test byte 0x34 resets 0x00, sample-ready byte 0x35 resets 0x04
// - data rate byte 0x36 and timebase byte 0x37 both reset 0x01
// - rate-sensor range byte at 0x38 resets 0x02, set over spi only
// - addressed word returned in the next 16 clocks; first word meaningless
`timescale 1ns/10ps
`default_nettype none
`include "spm_map.vh"

module spm_spi_port (
	// system clock and reset
	input wire mclk,
	input wire rst_n,
	// serial pins
	input wire spi_sclk,
	input wire spi_cs_n,
	input wire spi_mosi,
	output reg spi_miso_o,
	output reg spi_miso_oe,
	// timing inputs
	input wire ext_sync,
	input wire sample_tick,
	// sensor words from the measurement core
	input wire [15:0] gyro_x_out,
	input wire [15:0] gyro_y_out,
	input wire [15:0] gyro_z_out,
	input wire [15:0] accelerometer_x_out,
	input wire [15:0] accelerometer_y_out,
	input wire [15:0] accelerometer_z_out,
	input wire [15:0] magnetometer_x_out,
	input wire [15:0] magnetometer_y_out,
	input wire [15:0] magnetometer_z_out,
	input wire [15:0] gyro_temperature,
	input wire [15:0] pcb_temperature,
	// configuration to the measurement core
	output wire [7:0] builtin_test_ctrl,
	output wire [7:0] sample_ready_cfg,
	output wire [7:0] sample_rate_select,
	output wire [7:0] timebase_source_select,
	output wire [7:0] gyro_range_select,
	// status and strobes
	output reg bist_start_o,
	output reg sample_ready_o,
	output reg ext_timing_o
);

	// ------------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------------

	// bit order of the synchronised group
	localparam SYN_SCLK = 0;
	localparam SYN_CS_N = 1;
	localparam SYN_MOSI = 2;
	localparam SYN_SYNC = 3;

	wire [3:0] pins_s;

	// clock and select idle high, so they leave reset at their idle level
	spm_sync #(
		.WIDTH(4),
		.RST_VAL(4'h3)
	) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.din({ext_sync, spi_mosi, spi_cs_n, spi_sclk}),
		.dout(pins_s)
	);

	wire sclk_s = pins_s[SYN_SCLK];
	wire cs_act = ~pins_s[SYN_CS_N];
	wire mosi_s = pins_s[SYN_MOSI];
	wire sync_s = pins_s[SYN_SYNC];

	// ------------------------------------------------------------------------
	// edge detection on the synchronised pins
	// ------------------------------------------------------------------------

	reg sclk_d_q;
	reg sync_d_q;

	// previous levels, for edges; only second-stage outputs are looked at
	always @(posedge mclk) begin
		if (!rst_n) begin
			sclk_d_q <= 1'b1;
			sync_d_q <= 1'b0;
		end else begin
			sclk_d_q <= sclk_s;
			sync_d_q <= sync_s;
		end
	end

	// clock edges only count inside a frame; the master alone makes them
	wire sclk_rise = cs_act & sclk_s & ~sclk_d_q;
	wire sclk_fall = cs_act & ~sclk_s & sclk_d_q;
	wire sync_rise = sync_s & ~sync_d_q;

	// ------------------------------------------------------------------------
	// receive shifter and bit counter
	// ------------------------------------------------------------------------

	reg [3:0] bit_cnt_q;
	reg [3:0] bit_cnt_d;
	reg [14:0] rx_sh_q;
	reg [14:0] rx_sh_d;

	// a word is complete on its sixteenth rising edge
	wire word_done = sclk_rise & (bit_cnt_q == 4'hf);
	wire [15:0] rx_word = {rx_sh_q, mosi_s};

	// select high drops any partial word, so a short frame never decodes
	always @* begin
		bit_cnt_d = bit_cnt_q;
		rx_sh_d = rx_sh_q;
		if (!cs_act) begin
			bit_cnt_d = 4'h0;
		end else if (sclk_rise) begin
			bit_cnt_d = bit_cnt_q + 4'h1; // wraps to zero after a whole word
			rx_sh_d = {rx_sh_q[13:0], mosi_s}; // msb arrives first
		end
	end

	always @(posedge mclk) begin
		if (!rst_n) begin
			bit_cnt_q <= 4'h0;
			rx_sh_q <= 15'h0000;
		end else begin
			bit_cnt_q <= bit_cnt_d;
			rx_sh_q <= rx_sh_d;
		end
	end

	// ------------------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------------------

	wire [7:0] cmd_addr = rx_word[15:8];
	wire [7:0] cmd_data = rx_word[7:0];
	wire cmd_write = cmd_addr[`SPM_WR_FLAG_BIT];
	// address byte without the write flag
	wire [7:0] wr_addr = {1'b0, cmd_addr[6:0]};
	// reads always fetch the word at the even address of a pair
	wire [7:0] rd_addr = {cmd_addr[7:1], 1'b0};

	wire cfg_wr = word_done & cmd_write;
	wire cmd_read = word_done & ~cmd_write;

	// ------------------------------------------------------------------------
	// configuration bytes
	// ------------------------------------------------------------------------

	// range byte has no path but this write port
	spm_cfg_regs u_cfg (
		.mclk(mclk),
		.rst_n(rst_n),
		.wr_en(cfg_wr),
		.wr_addr(wr_addr),
		.wr_data(cmd_data),
		.builtin_test_ctrl(builtin_test_ctrl),
		.sample_ready_cfg(sample_ready_cfg),
		.sample_rate_select(sample_rate_select),
		.timebase_source_select(timebase_source_select),
		.gyro_range_select(gyro_range_select)
	);

	// ------------------------------------------------------------------------
	// read multiplexer
	// ------------------------------------------------------------------------

	reg ext_timing_q;
	reg [15:0] rd_word;
	reg [7:0] tbase_view;

	// timebase byte reads back with the lock flag in its top bit
	always @* begin
		tbase_view = timebase_source_select;
		tbase_view[`SPM_TBASE_LOCK_BIT] = ext_timing_q;
	end

	// sensor words pass unchanged; paired bytes come high byte first
	always @* begin
		case (rd_addr)
			`SPM_ADDR_GYRO_X: rd_word = gyro_x_out;
			`SPM_ADDR_GYRO_Y: rd_word = gyro_y_out;
			`SPM_ADDR_GYRO_Z: rd_word = gyro_z_out;
			`SPM_ADDR_ACCEL_X: rd_word = accelerometer_x_out;
			`SPM_ADDR_ACCEL_Y: rd_word = accelerometer_y_out;
			`SPM_ADDR_ACCEL_Z: rd_word = accelerometer_z_out;
			`SPM_ADDR_MAG_X: rd_word = magnetometer_x_out;
			`SPM_ADDR_MAG_Y: rd_word = magnetometer_y_out;
			`SPM_ADDR_MAG_Z: rd_word = magnetometer_z_out;
			`SPM_ADDR_GYRO_TEMP: rd_word = gyro_temperature;
			`SPM_ADDR_PCB_TEMP: rd_word = pcb_temperature;
			`SPM_ADDR_BIST: rd_word = {builtin_test_ctrl, sample_ready_cfg};
			`SPM_ADDR_RATE: rd_word = {sample_rate_select, tbase_view};
			`SPM_ADDR_RANGE: rd_word = {gyro_range_select, 8'h00};
			default: rd_word = 16'h0000; // reserved, reads as zero; the read still clears the ready flag
		endcase
	end

	// ------------------------------------------------------------------------
	// reply word
	// ------------------------------------------------------------------------

	reg [15:0] next_word_q;

	// captured at command end so the word is coherent while it shifts out;
	// it survives select going high, so a later frame can collect it
	always @(posedge mclk) begin
		if (!rst_n) begin
			next_word_q <= 16'h0000;
		end else if (cmd_read) begin
			next_word_q <= rd_word;
		end else if (cfg_wr) begin
			next_word_q <= 16'h0000; // a write leaves nothing to collect
		end
	end

	// ------------------------------------------------------------------------
	// transmit shifter and output pin
	// ------------------------------------------------------------------------

	reg [14:0] tx_sh_q;

	// the reply for word n goes out during word n+1; falling edge changes data
	always @(posedge mclk) begin
		if (!rst_n) begin
			tx_sh_q <= 15'h0000;
			spi_miso_o <= 1'b0;
		end else if (sclk_fall) begin
			if (bit_cnt_q == 4'h0) begin
				spi_miso_o <= next_word_q[15];
				tx_sh_q <= next_word_q[14:0];
			end else begin
				spi_miso_o <= tx_sh_q[14];
				tx_sh_q <= {tx_sh_q[13:0], 1'b0};
			end
		end
	end

	// the line is driven only while selected, shared with other slaves
	always @(posedge mclk) begin
		if (!rst_n) begin
			spi_miso_oe <= 1'b0;
		end else begin
			spi_miso_oe <= cs_act;
		end
	end

	// ------------------------------------------------------------------------
	// self-test start strobe
	// ------------------------------------------------------------------------

	// one cycle per write that sets the go bit
	always @(posedge mclk) begin
		if (!rst_n) begin
			bist_start_o <= 1'b0;
		end else begin
			bist_start_o <= cfg_wr & (wr_addr == `SPM_ADDR_BIST)
				& cmd_data[`SPM_BIST_GO_BIT];
		end
	end

	// ------------------------------------------------------------------------
	// external timebase lock
	// ------------------------------------------------------------------------

	// no software path clears the lock; only reset does, and a sync still
	// toggling after reset simply locks again, which is the intended limit
	always @(posedge mclk) begin
		if (!rst_n) begin
			ext_timing_q <= 1'b0;
		end else if (sync_rise) begin
			ext_timing_q <= 1'b1;
		end
	end

	always @(posedge mclk) begin
		if (!rst_n) begin
			ext_timing_o <= 1'b0;
		end else begin
			ext_timing_o <= ext_timing_q;
		end
	end

	// ------------------------------------------------------------------------
	// sample-ready output
	// ------------------------------------------------------------------------

	reg rdy_pend_q;
	reg rdy_pend_d;
	wire rdy_en = sample_ready_cfg[`SPM_READY_EN_BIT];
	wire rdy_pol = sample_ready_cfg[`SPM_READY_POL_BIT];

	// a new sample wins over the clear made by a completed read
	always @* begin
		rdy_pend_d = rdy_pend_q;
		if (cmd_read) begin
			rdy_pend_d = 1'b0;
		end
		if (sample_tick) begin
			rdy_pend_d = 1'b1;
		end
	end

	always @(posedge mclk) begin
		if (!rst_n) begin
			rdy_pend_q <= 1'b0;
		end else begin
			rdy_pend_q <= rdy_pend_d;
		end
	end

	// when disabled the pin rests at its inactive level
	always @(posedge mclk) begin
		if (!rst_n) begin
			sample_ready_o <= 1'b1;
		end else if (rdy_en) begin
			sample_ready_o <= rdy_pend_d ~^ rdy_pol;
		end else begin
			sample_ready_o <= ~rdy_pol;
		end
	end

endmodule // spm_spi_port

`default_nettype wire

// ### verif/spm_spi_port_chk.sv
// assertion checker for the pins of the spi register port
`timescale 1ns/10ps
`default_nettype none
module spm_spi_port_chk (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// serial pins and timing input
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_miso_o,
	input wire logic spi_miso_oe,
	input wire logic ext_sync,
	// status and configuration outputs
	input wire logic bist_start_o,
	input wire logic ext_timing_o,
	input wire logic [7:0] builtin_test_ctrl,
	input wire logic [7:0] sample_ready_cfg,
	input wire logic [7:0] sample_rate_select,
	input wire logic [7:0] timebase_source_select,
	input wire logic [7:0] gyro_range_select
);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// five cycles cover the select synchroniser lag
	property p_oe_off; spi_cs_n [*5] |-> !spi_miso_oe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("miso driven while idle");
	property p_oe_on; !spi_cs_n [*5] |-> spi_miso_oe; endproperty
	a_oe_on: assert property (p_oe_on) else $error("miso idle in frame");
	// only falling edges move miso, so it holds after a rise
	property p_miso_hold; $rose(spi_sclk) && !spi_cs_n |=> $stable(spi_miso_o) [*4]; endproperty
	a_miso_hold: assert property (p_miso_hold) else $error("miso moved after rise");
	// reset values show on the first edge after release
	property p_rst_34; $rose(rst_n) |-> builtin_test_ctrl == 8'h00 && sample_ready_cfg == 8'h04;
	endproperty
	a_rst_34: assert property (p_rst_34) else $error("pair 34 reset value");
	property p_rst_36; $rose(rst_n) |-> sample_rate_select == 8'h01 && timebase_source_select == 8'h01;
	endproperty
	a_rst_36: assert property (p_rst_36) else $error("pair 36 reset value");
	property p_rst_38; $rose(rst_n) |-> gyro_range_select == 8'h02; endproperty
	a_rst_38: assert property (p_rst_38) else $error("range reset value");
	// bytes move only as a word completes inside a frame
	property p_cfg_spi; $changed({builtin_test_ctrl, sample_ready_cfg, sample_rate_select,
		timebase_source_select, gyro_range_select}) |-> !$past(spi_cs_n, 3); endproperty
	a_cfg_spi: assert property (p_cfg_spi) else $error("config changed outside frame");
	// lock is sticky until reset and needs a sync edge
	property p_lock_hold; ext_timing_o |=> ext_timing_o; endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("lock dropped");
	property p_lock_set; $rose(ext_sync) |-> ##[2:8] ext_timing_o; endproperty
	a_lock_set: assert property (p_lock_set) else $error("lock not taken");
	// two sync stages, the edge detect and the lock and output flops: the pin was high 4 back
	property p_lock_cause; $rose(ext_timing_o) |-> $past(ext_sync, 4); endproperty
	a_lock_cause: assert property (p_lock_cause) else $error("lock without sync");
	// go strobe is one cycle and follows a stored go bit
	property p_bist; bist_start_o |=> !bist_start_o && builtin_test_ctrl[2]; endproperty
	a_bist: assert property (p_bist) else $error("self-test strobe wrong");
endmodule // spm_spi_port_chk

bind spm_spi_port spm_spi_port_chk spm_spi_port_chk_i (.mclk(mclk), .rst_n(rst_n),
	.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_miso_o(spi_miso_o),
	.spi_miso_oe(spi_miso_oe), .ext_sync(ext_sync), .bist_start_o(bist_start_o),
	.ext_timing_o(ext_timing_o), .builtin_test_ctrl(builtin_test_ctrl),
	.sample_ready_cfg(sample_ready_cfg), .sample_rate_select(sample_rate_select),
	.timebase_source_select(timebase_source_select), .gyro_range_select(gyro_range_select));
`default_nettype wire

// ### verif/spm_master_model.sv
// spi master model sending mode 3 words to the register port
`timescale 1ns/10ps
`default_nettype none
module spm_master_model (
	// system clock paces the pins
	input wire logic mclk,
	// serial pins
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic spi_mosi,
	input wire logic spi_miso
);
	// ------------------------------------------------------------
	// frame engine
	// ------------------------------------------------------------
	int hc = 7; // half period in cycles; 7 keeps the clock under 2 MHz
	// idle: clock high, deselected
	initial begin
		spi_sclk = 1'b1;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end
	// one word msb first; cs raised on last word or abort
	task automatic word(input logic [15:0] tx, output logic [15:0] rx, input bit last,
		input int nb = 16);
		rx = 16'h0000;
		if (spi_cs_n) begin
			spi_cs_n = 1'b0; // master opens every frame
			repeat (hc) @(negedge mclk);
		end
		for (int i = 15; i > 15 - nb; i--) begin
			spi_sclk = 1'b0; // data moves on the fall
			spi_mosi = tx[i];
			repeat (hc) @(negedge mclk);
			spi_sclk = 1'b1;
			rx[i] = spi_miso; // taken at the rise
			repeat (hc) @(negedge mclk);
		end
		if (last || nb < 16) begin
			spi_cs_n = 1'b1; // last or aborted word closes a chain
			spi_mosi = ~spi_mosi; // released line shows no stale bit
			repeat (3 * hc) @(negedge mclk);
		end
	endtask
endmodule // spm_master_model
`default_nettype wire

// ### verif/tb_spm_spi_port.sv
// self-checking bench for the spi register port
`timescale 1ns/10ps
`default_nettype none
module tb_spm_spi_port;
	// ------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------
	logic mclk, rst_n, ext_sync, sample_tick, miso_last, lock_exp;
	wire logic sclk, cs_n, mosi, miso, miso_o, miso_oe, ready, lock, bist;
	wire logic [7:0] cfg [5];
	logic [15:0] sens [11];
	logic [15:0] rx;
	logic [7:0] cfgw [5];
	logic [7:0] lst [14] = '{8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h10, 8'h12,
		8'h14, 8'h16, 8'h18, 8'h1a, 8'h05, 8'h00};
	int fails, comparisons, seed, r, bist_seen, bist_exp;
	// free-running system clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// undriven miso shows the inverse of its last bit
	always @(posedge mclk) begin
		if (!rst_n)
			miso_last <= 1'b0;
		else if (miso_oe)
			miso_last <= miso_o;
	end
	// self-test strobes, counted against the writes that set the go bit
	always @(posedge mclk) if (bist) bist_seen <= bist_seen + 1;
	assign miso = miso_oe ? miso_o : ~miso_last;
	spm_spi_port spm_spi_port_i (.mclk(mclk), .rst_n(rst_n), .spi_sclk(sclk),
		.spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso_o(miso_o), .spi_miso_oe(miso_oe),
		.ext_sync(ext_sync), .sample_tick(sample_tick), .gyro_x_out(sens[0]),
		.gyro_y_out(sens[1]), .gyro_z_out(sens[2]), .accelerometer_x_out(sens[3]),
		.accelerometer_y_out(sens[4]), .accelerometer_z_out(sens[5]),
		.magnetometer_x_out(sens[6]), .magnetometer_y_out(sens[7]),
		.magnetometer_z_out(sens[8]), .gyro_temperature(sens[9]), .pcb_temperature(sens[10]),
		.builtin_test_ctrl(cfg[0]), .sample_ready_cfg(cfg[1]), .sample_rate_select(cfg[2]),
		.timebase_source_select(cfg[3]), .gyro_range_select(cfg[4]), .bist_start_o(bist),
		.sample_ready_o(ready), .ext_timing_o(lock));
	spm_master_model spm_master_model_i (.mclk(mclk), .spi_sclk(sclk), .spi_cs_n(cs_n),
		.spi_mosi(mosi), .spi_miso(miso));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// reply word of a read, pair bytes from the even address
	function automatic logic [15:0] exp_rd(input logic [7:0] a);
		logic [7:0] e;
		e = {a[7:1], 1'b0};
		if (e >= 8'h04 && e <= 8'h18) return sens[(e - 8'h04) >> 1];
		case (e)
			8'h34: return {cfgw[0], cfgw[1]};
			8'h36: return {cfgw[2], lock_exp, cfgw[3][6:0]};
			8'h38: return {cfgw[4], 8'h00};
			default: return 16'h0000;
		endcase
	endfunction
	task automatic rd(input logic [7:0] a);
		spm_master_model_i.word({a, 8'h00}, rx, 1'b0);
		spm_master_model_i.word(16'h0000, rx, 1'b1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		spm_master_model_i.word({1'b1, a[6:0], d}, rx, 1'b1);
	endtask
	task automatic do_reset();
		rst_n = 1'b0;
		repeat (4) @(negedge mclk);
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		cfgw = '{8'h00, 8'h04, 8'h01, 8'h01, 8'h02};
		lock_exp = 1'b0;
	endtask
	task automatic check_all();
		for (int i = 0; i < 5; i++)
			chk("cfg byte", {8'h00, cfgw[i]}, {8'h00, cfg[i]});
		for (int a = 8'h34; a <= 8'h38; a += 2) begin
			rd(a[7:0]);
			chk("pair read", exp_rd(a[7:0]), rx);
		end
		chk("lock", {15'h0000, lock_exp}, {15'h0000, lock});
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		seed = 32'h7ca2;
		{rst_n, ext_sync, sample_tick} = 3'h0;
		fails = 0;
		comparisons = 0;
		bist_exp = 0;
		foreach (sens[i]) sens[i] = 16'($random(seed));
		do_reset();
		check_all();
		// default byte enables the ready flag, active low
		sample_tick = 1'b1;
		@(negedge mclk) sample_tick = 1'b0;
		repeat (4) @(negedge mclk);
		chk("ready set", 16'h0000, {15'h0000, ready});
		rd(8'h34);
		chk("ready clear", 16'h0001, {15'h0000, ready});
		// one slow chained frame over all sensor words, a reserved and an odd address
		foreach (sens[i]) sens[i] = 16'($random(seed));
		spm_master_model_i.hc = 12;
		for (int i = 0; i < 14; i++) begin
			spm_master_model_i.word({lst[i], 8'h00}, rx, i == 13);
			if (i > 0)
				chk("chained read", exp_rd(lst[i - 1]), rx);
		end
		// aborted write word must leave the range byte alone
		spm_master_model_i.hc = 7;
		spm_master_model_i.word(16'hb8ff, rx, 1'b0, 12);
		check_all();
		// corner: go bit alone, so at least one strobe is always seen
		wr(8'h34, 8'h04);
		bist_exp++;
		// random bytes everywhere, then writes to read-only places
		repeat (3) begin
			for (int i = 0; i < 5; i++) begin
				r = $random(seed);
				wr(8'h34 + 8'(i), r[7:0]);
				cfgw[i] = r[7:0];
				if (i == 0 && r[2])
					bist_exp++;
			end
			wr(8'h04, r[15:8]);
			wr(8'h1c, r[23:16]);
			check_all();
			rd(8'h04);
			chk("ro word", sens[0], rx);
		end
		chk("bist pulses", 16'(bist_exp), 16'(bist_seen));
		// sync pulse locks, reset with sync low unlocks
		ext_sync = 1'b1;
		repeat (10) @(negedge mclk);
		ext_sync = 1'b0;
		repeat (4) @(negedge mclk);
		lock_exp = 1'b1;
		check_all();
		do_reset();
		check_all();
		report_and_stop();
	end
	// hang guard, about twice the expected run
	initial begin
		#2000000;
		fails++;
		report_and_stop();
	end
endmodule // tb_spm_spi_port
`default_nettype wire
